/* verilog/lin_consts.svh */
// offsets, field positions, reset values and counts of the interpolation start
`ifndef LIN_CONSTS_SVH
`define LIN_CONSTS_SVH

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_MASK 8'h0C
`define REG_X_POS 8'h10
`define REG_Y_POS 8'h14
`define REG_AUX_SPEED 8'h18
`define REG_AUX_BIAS 8'h1C
`define REG_AUX_TIMES 8'h20

`define CTRL_ADV_BIT 0
`define CTRL_ERR_CLR_BIT 1
`define ST_BUSY_BIT 0
`define ST_MAIN_Y_BIT 1
`define ST_INSTR_ERR_BIT 2
`define ST_X_ERR_BIT 3
`define ST_Y_ERR_BIT 4
`define ST_CODE_LSB 16

`define INT_W 3
`define INT_DONE_BIT 0
`define INT_INSTR_ERR_BIT 1
`define INT_AXIS_ERR_BIT 2
`define INT_MASK_RESET 3'h0

`define AXIS_OPERAND_MAX 16'h0001
`define AXIS_SELECT_XY 16'h0003
`define STEP_MAX_STD 16'h001E
`define STEP_MAX_ADV 16'h0050
`define ERR_CODE_SELECT 16'h00FD
`define ERR_CODE_Y_BUSY 16'h00F2
`define ERR_CODE_NONE 16'h0000

`define FRAC_W 16
`define CLK_PERIOD_NS 10
`define NS_PER_S 1000000000
`define CLK_HZ (`NS_PER_S / `CLK_PERIOD_NS)

`endif

/* verilog/lin_pkg.sv */
// types shared by the two-axis interpolation start logic
package lin_pkg;

  typedef enum logic [1:0] {
    PAT_END,
    PAT_CONTINUED,
    PAT_INCESSANT,
    PAT_RESERVED
  } pattern_t;

  typedef struct packed {
    logic absolute;
    pattern_t pattern;
    logic signed [31:0] target;
    logic [31:0] speed;
    logic [15:0] acc_time;
    logic [15:0] dec_time;
    logic [31:0] bias;
  } step_data_t;

  typedef struct packed {
    logic [15:0] slot_operand;
    logic [15:0] axis_operand;
    logic [15:0] step_operand;
    logic [15:0] axis_select_operand;
  } lin_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD,
    ST_DIVIDE,
    ST_SCALE,
    ST_RUN
  } lin_state_t;

endpackage : lin_pkg

/* verilog/two_axis_linear_interp_start.sv */
// two-axis straight-line interpolation start and pulse stepping
// Overview of operation
// - start only on a rising edge of the input condition, never on level
// - both axes move so the combined path is a straight line to target
// - target is absolute or incremental per the step's coordinate setting
// - larger travel axis becomes main axis; on a tie axis X is main
// - auxiliary speed is main speed times aux over main distance, auto times
// - only End and Continued patterns; anything else runs as End
// - main axis Continued raises no error and chains to the next step
// - auxiliary axis Continued setting has no effect
// - axis select bit 0 is X, bit 1 is Y, bit 2 absent, 15..3 unused
// - axis select other than 3 reports code 253 and no motion
// - axis operand not 0 or 1 sets instruction error only, no motion
// - step outside 0~30 or 0~80 sets axis error, not instruction error
// - the step operand picks the same step data for both axes
// - axis operand value in range does not steer motion
// - refuse while X operates or is in error; Y busy gives code 242
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "lin_consts.svh"

module two_axis_linear_interp_start #(
  parameter int STEP_W = 7,
  parameter logic [15:0] STEP_ERR_CODE = 16'h0001
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // instruction from the sequence program
  input wire logic start_cond_in,
  input wire lin_pkg::lin_cmd_t cmd_in,
  input wire logic y_axis_busy_in,
  // step data fetch
  output logic [STEP_W-1:0] step_addr_out,
  input wire lin_pkg::step_data_t step_x_in,
  input wire lin_pkg::step_data_t step_y_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  // flags
  output logic instruction_error_flag_out,
  output logic x_axis_error_flag_out,
  output logic y_axis_error_flag_out,
  output logic x_axis_busy_flag_out,
  output logic [15:0] error_code_out,
  // pulse outputs
  output logic x_pulse_out,
  output logic x_dir_out,
  output logic y_pulse_out,
  output logic y_dir_out
);

  localparam logic [32:0] CLK_HZ = 33'(`CLK_HZ);

  lin_pkg::lin_state_t state;
  logic prev_cond;
  logic ctrl_adv;
  logic [`INT_W-1:0] int_status;
  logic [`INT_W-1:0] int_mask;
  logic signed [31:0] x_pos;
  logic signed [31:0] y_pos;
  logic main_is_y;
  logic main_cont;
  logic [31:0] main_dist;
  logic [31:0] aux_dist;
  logic [31:0] main_left;
  logic [31:0] main_speed;
  logic [31:0] main_bias;
  logic [31:0] aux_speed;
  logic [31:0] aux_bias;
  logic [15:0] aux_acc;
  logic [15:0] aux_dec;
  logic [33:0] rem;
  logic [`FRAC_W:0] quo;
  logic [4:0] bit_cnt;
  logic [32:0] phase;
  logic [32:0] err_acc;
  logic done_evt;

  // -------------------------------------------------------------
  // distance of one axis
  // -------------------------------------------------------------
  function automatic logic [32:0] travel(input lin_pkg::step_data_t s,
                                         input logic signed [31:0] pos);
    logic signed [32:0] diff;
    diff = s.absolute ? 33'(s.target) - 33'(pos) : 33'(s.target);
    travel = diff[32] ? {1'b1, 32'(-diff)} : {1'b0, diff[31:0]};
  endfunction : travel

  // -------------------------------------------------------------
  // start decode
  // -------------------------------------------------------------
  logic cond_edge;
  logic axis_ok;
  logic step_ok;
  logic select_ok;
  logic start_ok;
  logic [15:0] step_max;
  logic [32:0] x_trav;
  logic [32:0] y_trav;
  logic y_main;

  assign step_max = ctrl_adv ? `STEP_MAX_ADV : `STEP_MAX_STD;
  assign cond_edge = start_cond_in && !prev_cond;
  assign axis_ok = cmd_in.axis_operand <= `AXIS_OPERAND_MAX;
  assign step_ok = cmd_in.step_operand <= step_max;
  assign select_ok = cmd_in.axis_select_operand == `AXIS_SELECT_XY;
  assign start_ok = cond_edge && axis_ok && !x_axis_busy_flag_out &&
                    !x_axis_error_flag_out && step_ok && select_ok &&
                    !y_axis_busy_in;
  assign x_trav = travel(step_x_in, x_pos);
  assign y_trav = travel(step_y_in, y_pos);
  assign y_main = y_trav[31:0] > x_trav[31:0];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_cond <= 1'b0;
    end else begin
      prev_cond <= start_cond_in;
    end
  end

  // -------------------------------------------------------------
  // step pacing
  // -------------------------------------------------------------
  logic [32:0] next_phase;
  logic tick;
  logic [32:0] next_err;
  logic aux_hit;
  logic [48:0] speed_prod;
  logic [48:0] bias_prod;
  logic [33:0] rem_diff;

  assign next_phase = phase + {1'b0, main_speed};
  assign tick = next_phase >= CLK_HZ;
  assign next_err = err_acc + {1'b0, aux_dist};
  assign aux_hit = next_err >= {1'b0, main_dist};
  assign speed_prod = main_speed * quo;
  assign bias_prod = main_bias * quo;
  assign rem_diff = rem - {2'b00, main_dist};

  // -------------------------------------------------------------
  // sequencer and motion
  // -------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= lin_pkg::ST_IDLE;
      step_addr_out <= '0;
      x_axis_busy_flag_out <= 1'b0;
      x_pulse_out <= 1'b0;
      y_pulse_out <= 1'b0;
      x_dir_out <= 1'b0;
      y_dir_out <= 1'b0;
      main_is_y <= 1'b0;
      main_cont <= 1'b0;
      main_dist <= '0;
      aux_dist <= '0;
      main_left <= '0;
      main_speed <= '0;
      main_bias <= '0;
      aux_speed <= '0;
      aux_bias <= '0;
      aux_acc <= '0;
      aux_dec <= '0;
      rem <= '0;
      quo <= '0;
      bit_cnt <= '0;
      phase <= '0;
      err_acc <= '0;
      done_evt <= 1'b0;
    end else begin
      x_pulse_out <= 1'b0;
      y_pulse_out <= 1'b0;
      done_evt <= 1'b0;
      case (state)
        lin_pkg::ST_IDLE: begin
          if (start_ok) begin
            step_addr_out <= cmd_in.step_operand[STEP_W-1:0];
            x_axis_busy_flag_out <= 1'b1;
            state <= lin_pkg::ST_FETCH;
          end
        end
        lin_pkg::ST_FETCH: begin
          state <= lin_pkg::ST_LOAD;
        end
        lin_pkg::ST_LOAD: begin
          main_is_y <= y_main;
          x_dir_out <= x_trav[32];
          y_dir_out <= y_trav[32];
          main_dist <= y_main ? y_trav[31:0] : x_trav[31:0];
          aux_dist <= y_main ? x_trav[31:0] : y_trav[31:0];
          main_speed <= y_main ? step_y_in.speed : step_x_in.speed;
          main_bias <= y_main ? step_y_in.bias : step_x_in.bias;
          aux_acc <= y_main ? step_y_in.acc_time : step_x_in.acc_time;
          aux_dec <= y_main ? step_y_in.dec_time : step_x_in.dec_time;
          main_cont <= (y_main ? step_y_in.pattern : step_x_in.pattern)
                       == lin_pkg::PAT_CONTINUED;
          rem <= {2'b00, y_main ? x_trav[31:0] : y_trav[31:0]};
          quo <= '0;
          bit_cnt <= '0;
          state <= lin_pkg::ST_DIVIDE;
        end
        lin_pkg::ST_DIVIDE: begin
          // ratio of aux to main distance as a 16-bit fraction
          if (rem >= {2'b00, main_dist}) begin
            quo <= {quo[`FRAC_W-1:0], 1'b1};
            rem <= {rem_diff[32:0], 1'b0};
          end else begin
            quo <= {quo[`FRAC_W-1:0], 1'b0};
            rem <= {rem[32:0], 1'b0};
          end
          bit_cnt <= 5'(bit_cnt + 5'h01);
          if (bit_cnt == 5'(`FRAC_W)) begin
            state <= lin_pkg::ST_SCALE;
          end
        end
        lin_pkg::ST_SCALE: begin
          aux_speed <= (main_dist == '0) ? '0 : speed_prod[47:16];
          aux_bias <= (main_dist == '0) ? '0 : bias_prod[47:16];
          main_left <= main_dist;
          phase <= '0;
          err_acc <= '0;
          state <= lin_pkg::ST_RUN;
        end
        lin_pkg::ST_RUN: begin
          if (main_left == '0) begin
            if (main_cont && 16'(step_addr_out) < step_max) begin
              step_addr_out <= STEP_W'(step_addr_out + 1'b1);
              state <= lin_pkg::ST_FETCH;
            end else begin
              done_evt <= 1'b1;
              x_axis_busy_flag_out <= 1'b0;
              state <= lin_pkg::ST_IDLE;
            end
          end else begin
            phase <= tick ? 33'(next_phase - CLK_HZ) : next_phase;
            if (tick) begin
              main_left <= main_left - 32'h0000_0001;
              x_pulse_out <= main_is_y ? aux_hit : 1'b1;
              y_pulse_out <= main_is_y ? 1'b1 : aux_hit;
              err_acc <= aux_hit ? 33'(next_err - {1'b0, main_dist})
                                 : next_err;
            end
          end
        end
        default: begin
          state <= lin_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // current positions
  // -------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      x_pos <= '0;
      y_pos <= '0;
    end else begin
      if (x_pulse_out) begin
        x_pos <= x_dir_out ? x_pos - 32'sd1 : x_pos + 32'sd1;
      end
      if (y_pulse_out) begin
        y_pos <= y_dir_out ? y_pos - 32'sd1 : y_pos + 32'sd1;
      end
    end
  end

  // -------------------------------------------------------------
  // error flags and codes
  // -------------------------------------------------------------
  logic err_clr;
  logic step_fail;
  logic select_fail;
  logic ybusy_fail;
  logic checks_go;

  assign err_clr = reg_write_in && reg_addr_in == `REG_CTRL &&
                   reg_wdata_in[`CTRL_ERR_CLR_BIT];
  assign checks_go = cond_edge && axis_ok && !x_axis_busy_flag_out &&
                     !x_axis_error_flag_out;
  assign step_fail = checks_go && !step_ok;
  assign select_fail = checks_go && step_ok && !select_ok;
  assign ybusy_fail = checks_go && step_ok && select_ok && y_axis_busy_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instruction_error_flag_out <= 1'b0;
      x_axis_error_flag_out <= 1'b0;
      y_axis_error_flag_out <= 1'b0;
      error_code_out <= `ERR_CODE_NONE;
    end else begin
      if (cond_edge) begin
        instruction_error_flag_out <= !axis_ok;
      end
      if (err_clr) begin
        x_axis_error_flag_out <= 1'b0;
        y_axis_error_flag_out <= 1'b0;
        error_code_out <= `ERR_CODE_NONE;
      end
      if (step_fail) begin
        x_axis_error_flag_out <= 1'b1;
        error_code_out <= STEP_ERR_CODE;
      end
      if (select_fail) begin
        x_axis_error_flag_out <= 1'b1;
        error_code_out <= `ERR_CODE_SELECT;
      end
      if (ybusy_fail) begin
        y_axis_error_flag_out <= 1'b1;
        error_code_out <= `ERR_CODE_Y_BUSY;
      end
    end
  end

  // -------------------------------------------------------------
  // registers and interrupt
  // -------------------------------------------------------------
  logic [`INT_W-1:0] int_set;
  logic [`INT_W-1:0] int_clr;
  logic [`INT_W-1:0] next_int_status;
  logic [31:0] status_word;

  assign int_set = {step_fail || select_fail || ybusy_fail,
                    cond_edge && !axis_ok, done_evt};
  assign int_clr = (reg_write_in && reg_addr_in == `REG_INT_STATUS) ?
                   reg_wdata_in[`INT_W-1:0] : '0;
  assign next_int_status = (int_status & ~int_clr) | int_set;
  assign status_word = {error_code_out, 11'h000, y_axis_error_flag_out,
                        x_axis_error_flag_out, instruction_error_flag_out,
                        main_is_y, x_axis_busy_flag_out};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_adv <= 1'b0;
      int_status <= '0;
      int_mask <= `INT_MASK_RESET;
      irq_out <= 1'b0;
      reg_rdata_out <= '0;
    end else begin
      int_status <= next_int_status;
      irq_out <= |(next_int_status & int_mask);
      if (reg_write_in && reg_addr_in == `REG_CTRL) begin
        ctrl_adv <= reg_wdata_in[`CTRL_ADV_BIT];
      end
      if (reg_write_in && reg_addr_in == `REG_INT_MASK) begin
        int_mask <= reg_wdata_in[`INT_W-1:0];
      end
      reg_rdata_out <= '0;
      if (reg_read_in) begin
        case (reg_addr_in)
          `REG_CTRL: reg_rdata_out <= {31'h0000_0000, ctrl_adv};
          `REG_STATUS: reg_rdata_out <= status_word;
          `REG_INT_STATUS: reg_rdata_out <= {29'h0000_0000, int_status};
          `REG_INT_MASK: reg_rdata_out <= {29'h0000_0000, int_mask};
          `REG_X_POS: reg_rdata_out <= x_pos;
          `REG_Y_POS: reg_rdata_out <= y_pos;
          `REG_AUX_SPEED: reg_rdata_out <= aux_speed;
          `REG_AUX_BIAS: reg_rdata_out <= aux_bias;
          `REG_AUX_TIMES: reg_rdata_out <= {aux_dec, aux_acc};
          default: reg_rdata_out <= '0;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence seq_edge_req;
    start_cond_in && !prev_cond && !x_axis_busy_flag_out &&
    !x_axis_error_flag_out && axis_ok;
  endsequence

  sequence seq_select_bad;
    seq_edge_req ##0 step_ok && !select_ok;
  endsequence

  AST_EDGE_START: assert property (
    $rose(x_axis_busy_flag_out) |->
      $past(start_cond_in) && !$past(prev_cond))
    else $error("motion began without a rising edge");

  AST_XERR_BLOCKS: assert property (
    x_axis_error_flag_out && state == lin_pkg::ST_IDLE |=>
      state == lin_pkg::ST_IDLE)
    else $error("start taken while axis X in error");

  AST_MAIN_LONGER: assert property (
    state == lin_pkg::ST_RUN |-> main_dist >= aux_dist)
    else $error("main axis travel shorter than auxiliary");

  AST_AUX_SLOWER: assert property (
    state == lin_pkg::ST_RUN |-> aux_speed <= main_speed)
    else $error("auxiliary speed above main speed");

  AST_AUX_WITH_MAIN: assert property (
    (main_is_y ? x_pulse_out : y_pulse_out) |->
      (main_is_y ? y_pulse_out : x_pulse_out))
    else $error("auxiliary step without main step");

  AST_AXIS_OPERAND: assert property (
    cond_edge && !axis_ok |=> instruction_error_flag_out &&
      $stable(x_axis_error_flag_out) && $stable(y_axis_error_flag_out))
    else $error("bad axis operand not reported correctly");

  AST_SELECT_CODE: assert property (
    seq_select_bad |=> error_code_out == `ERR_CODE_SELECT &&
      x_axis_error_flag_out ##1 state == lin_pkg::ST_IDLE)
    else $error("bad axis select not refused with its code");

  AST_STEP_RANGE: assert property (
    seq_edge_req ##0 !step_ok |=> x_axis_error_flag_out &&
      !instruction_error_flag_out && !x_axis_busy_flag_out)
    else $error("step out of range not reported on axis flag");

  AST_Y_BUSY: assert property (
    seq_edge_req ##0 step_ok && select_ok && y_axis_busy_in |=>
      error_code_out == `ERR_CODE_Y_BUSY && !x_axis_busy_flag_out)
    else $error("axis Y busy not refused with its code");

  AST_FETCH_STEP: assert property (
    $rose(x_axis_busy_flag_out) |->
      step_addr_out == $past(cmd_in.step_operand[STEP_W-1:0]))
    else $error("fetched step differs from step operand");

endmodule : two_axis_linear_interp_start

/* dv/lin_step_store.sv */
// step data table answering the block's fetch address
`timescale 1ns/1ps

module lin_step_store #(
  parameter int STEP_W = 7,
  parameter logic [31:0] SPEED = 32'h017D7840,
  parameter logic [31:0] BIAS = 32'h000003E8,
  parameter logic [15:0] ACC = 16'h0064,
  parameter logic [15:0] DEC = 16'h00C8
) (
  // fetch address
  input wire logic [STEP_W-1:0] step_addr_in,
  // step data of both axes
  output lin_pkg::step_data_t step_x_out,
  output lin_pkg::step_data_t step_y_out
);
  lin_pkg::step_data_t tab_x [0:(1<<STEP_W)-1];
  lin_pkg::step_data_t tab_y [0:(1<<STEP_W)-1];

  // one step number serves both axes
  assign step_x_out = tab_x[step_addr_in];
  assign step_y_out = tab_y[step_addr_in];

  task automatic put(input int n, input logic ab,
                     input lin_pkg::pattern_t px, input int tx,
                     input lin_pkg::pattern_t py, input int ty);
    tab_x[n] = '{absolute: ab, pattern: px, target: 32'(tx), speed: SPEED,
                 acc_time: ACC, dec_time: DEC, bias: BIAS};
    tab_y[n] = '{absolute: ab, pattern: py, target: 32'(ty), speed: SPEED,
                 acc_time: ACC, dec_time: DEC, bias: BIAS};
  endtask : put

  initial begin
    for (int i = 0; i < (1 << STEP_W); i++) begin
      put(i, 1'b0, lin_pkg::PAT_END, 0, lin_pkg::PAT_END, 0);
    end
  end
endmodule : lin_step_store

/* dv/two_axis_linear_interp_start_test.sv */
// self-checking bench of the two-axis interpolation start logic
`timescale 1ns/1ps
`include "lin_consts.svh"

module two_axis_linear_interp_start_test;
  localparam logic [15:0] ERRC = 16'h0001;
  localparam longint SPD = 64'h017D7840;
  localparam longint BIA = 64'h3E8;
  logic clk_in, rst_in, start_cond_in, y_axis_busy_in;
  lin_pkg::lin_cmd_t cmd_in;
  logic [6:0] step_addr_out;
  lin_pkg::step_data_t step_x_in, step_y_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, rv;
  logic reg_write_in, reg_read_in, irq_out, x_pulse_out, x_dir_out;
  logic instruction_error_flag_out, x_axis_error_flag_out;
  logic y_axis_error_flag_out, x_axis_busy_flag_out, y_pulse_out, y_dir_out;
  logic [15:0] error_code_out;
  int err_count, n_tests, bx, by;
  int xp = 0;
  int yp = 0;

  two_axis_linear_interp_start #(.STEP_W(7), .STEP_ERR_CODE(ERRC)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .start_cond_in(start_cond_in),
    .cmd_in(cmd_in), .y_axis_busy_in(y_axis_busy_in),
    .step_addr_out(step_addr_out), .step_x_in(step_x_in),
    .step_y_in(step_y_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out),
    .instruction_error_flag_out(instruction_error_flag_out),
    .x_axis_error_flag_out(x_axis_error_flag_out),
    .y_axis_error_flag_out(y_axis_error_flag_out),
    .x_axis_busy_flag_out(x_axis_busy_flag_out),
    .error_code_out(error_code_out), .x_pulse_out(x_pulse_out),
    .x_dir_out(x_dir_out), .y_pulse_out(y_pulse_out), .y_dir_out(y_dir_out)
  );

  lin_step_store #(.STEP_W(7)) store (
    .step_addr_in(step_addr_out),
    .step_x_out(step_x_in),
    .step_y_out(step_y_in)
  );

  // ----------------------------------------
  // clock and pulse counting
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (x_pulse_out === 1'b1) xp <= xp + 1;
    if (y_pulse_out === 1'b1) yp <= yp + 1;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 rv = reg_rdata_out;
  endtask : rd

  // flags packed as instr err, x err, y err, busy
  function automatic logic [31:0] flags();
    return {28'h0000000, instruction_error_flag_out, x_axis_error_flag_out,
            y_axis_error_flag_out, x_axis_busy_flag_out};
  endfunction : flags

  function automatic logic [31:0] scale(longint v, longint a, longint m);
    return 32'((v * ((a << 16) / m)) >> 16);
  endfunction : scale

  task automatic issue(input logic [15:0] ax, st, sel);
    @(posedge clk_in);
    start_cond_in <= 1'b1;
    cmd_in <= '{16'h0000, ax, st, sel};
    @(posedge clk_in);
    @(posedge clk_in);
    #1;
  endtask : issue

  task automatic drop();
    @(posedge clk_in);
    start_cond_in <= 1'b0;
  endtask : drop

  task automatic refused(input logic [15:0] ax, st, sel,
                         input logic [31:0] fl, input logic [15:0] code);
    issue(ax, st, sel);
    chk("flags", flags(), fl);
    chk("code", {16'h0000, error_code_out}, {16'h0000, code});
    drop();
    wr(`REG_CTRL, 32'h00000002);
  endtask : refused

  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_in);
      #1;
      if (x_axis_busy_flag_out === 1'b0) return;
    end
    chk("busy timeout", {31'h0, x_axis_busy_flag_out}, 32'h0);
    report_and_stop();
  endtask : wait_idle

  task automatic move(input logic [15:0] ax, st, input int ex, ey,
                      input logic [31:0] px, py, input logic mainy);
    bx = xp;
    by = yp;
    issue(ax, st, 16'h0003);
    chk("busy", flags(), 32'h00000001);
    repeat (19) @(posedge clk_in);
    rd(`REG_STATUS);
    chk("main", rv & 32'h00000003, {30'h0, mainy, 1'b1});
    wait_idle();
    repeat (20) @(posedge clk_in);
    #1;
    chk("no restart", flags(), 32'h00000000);
    chk("x count", 32'(xp - bx), 32'(ex));
    chk("y count", 32'(yp - by), 32'(ey));
    rd(`REG_X_POS);
    chk("x pos", rv, px);
    rd(`REG_Y_POS);
    chk("y pos", rv, py);
    drop();
  endtask : move

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("flags", flags(), 32'h00000000);
    wr(`REG_STATUS, 32'hFFFFFFFF);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(`REG_STATUS);
    chk("status", rv, 32'h00000000);
    rd(`REG_INT_MASK);
    chk("mask", rv, 32'h00000000);
    rd(8'hFC);
    chk("unmapped", rv, 32'h00000000);
  endtask : t_reset

  task automatic t_irq();
    refused(16'h0002, 16'h0005, 16'h0003, 32'h00000008, 16'h0000);
    chk("irq masked", {31'h0, irq_out}, 32'h00000000);
    wr(`REG_INT_MASK, 32'h00000002);
    @(posedge clk_in);
    #1 chk("irq on", {31'h0, irq_out}, 32'h00000001);
    wr(`REG_INT_STATUS, 32'h00000002);
    @(posedge clk_in);
    #1 chk("irq off", {31'h0, irq_out}, 32'h00000000);
    wr(`REG_INT_MASK, 32'h00000000);
  endtask : t_irq

  task automatic t_refusals();
    logic [15:0] sels [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0007,
                              16'h8003};
    refused(16'h0000, 16'h001E, 16'h0000, 32'h00000004,
            `ERR_CODE_SELECT);
    refused(16'h0000, 16'h001F, 16'h0003, 32'h00000004, ERRC);
    wr(`REG_CTRL, 32'h00000001);
    refused(16'h0000, 16'h0050, 16'h0000, 32'h00000004,
            `ERR_CODE_SELECT);
    wr(`REG_CTRL, 32'h00000001);
    refused(16'h0001, 16'h0051, 16'h0003, 32'h00000004, ERRC);
    foreach (sels[i]) refused(16'h0000, 16'h0005, sels[i], 32'h00000004,
                              `ERR_CODE_SELECT);
    y_axis_busy_in <= 1'b1;
    refused(16'h0000, 16'h0005, 16'h0003, 32'h00000002,
            `ERR_CODE_Y_BUSY);
    y_axis_busy_in <= 1'b0;
  endtask : t_refusals

  task automatic t_x_lock();
    issue(16'h0000, 16'h001F, 16'h0003);
    drop();
    issue(16'h0000, 16'h000A, 16'h0003);
    chk("locked", flags(), 32'h00000004);
    drop();
    wr(`REG_CTRL, 32'h00000002);
    rd(`REG_X_POS);
    chk("x pos", rv, 32'h00000000);
  endtask : t_x_lock

  task automatic t_chain();
    wr(`REG_INT_MASK, 32'h00000001);
    move(16'h0000, 16'h000A, 8, 3, 32'h8, 32'h3, 1'b0);
    chk("irq done", {31'h0, irq_out}, 32'h00000001);
    rd(`REG_INT_STATUS);
    chk("done", rv & 32'h00000001, 32'h00000001);
    wr(`REG_INT_STATUS, 32'h00000001);
    @(posedge clk_in);
    #1 chk("irq clr", {31'h0, irq_out}, 32'h00000000);
  endtask : t_chain

  task automatic t_absolute();
    move(16'h0001, 16'h0014, 5, 6, 32'h3, 32'h9, 1'b1);
    rd(`REG_AUX_SPEED);
    chk("aux speed", rv, scale(SPD, 5, 6));
    rd(`REG_AUX_BIAS);
    chk("aux bias", rv, scale(BIA, 5, 6));
    rd(`REG_AUX_TIMES);
    chk("aux times", rv, 32'h00C80064);
  endtask : t_absolute

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    n_tests = 0;
    bx = 0;
    by = 0;
    rst_in = 1'b1;
    start_cond_in = 1'b0;
    y_axis_busy_in = 1'b0;
    cmd_in = '0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h00000000;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    store.put(10, 1'b0, lin_pkg::PAT_CONTINUED, 7, lin_pkg::PAT_END, 2);
    store.put(11, 1'b0, lin_pkg::PAT_END, 1, lin_pkg::PAT_CONTINUED, 1);
    store.put(12, 1'b0, lin_pkg::PAT_END, 5, lin_pkg::PAT_END, 5);
    store.put(20, 1'b1, lin_pkg::PAT_END, 3, lin_pkg::PAT_END, 9);
    store.put(21, 1'b0, lin_pkg::PAT_END, -2, lin_pkg::PAT_END, 2);
    t_reset();
    t_irq();
    t_refusals();
    t_x_lock();
    t_chain();
    t_absolute();
    move(16'h0001, 16'h0015, 2, 2, 32'h1, 32'hB, 1'b0);
    report_and_stop();
  end
endmodule : two_axis_linear_interp_start_test
